//--- dv/plc_properties.sv
// Purpose: port-level checks of plc_top
// Assumes: apb access phase of two cycles, outputs registered
// Notes: bound to plc_top at the foot of this file
`timescale 1ns/10ps
`include "plc_regs.svh"
module plc_properties #(
  parameter int unsigned ADDR_W = `PLC_ADDR_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic crystal_clock_i,
  input wire logic oscillator_enable_i,
  input wire logic crystal_clock_o,
  input wire logic base_clock_out_o,
  input wire logic clockgen_irq_o,
  input wire logic auto_mode_o
);
  default clocking dcb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic acc;

  // a transfer completes in this cycle
  assign acc = psel_i && penable_i && pready_o;

  // steps of a bus transfer
  sequence s_rd_done;
    acc && !pwrite_i && !pslverr_o;
  endsequence
  sequence s_ie_off;
    acc && pwrite_i && paddr_i == `PLC_CTRL_OFF && !pwdata_i[`PLC_CTRL_IE_BIT];
  endsequence

  property p_stop_quiet;
    !oscillator_enable_i |=> !clockgen_irq_o && !base_clock_out_o && !crystal_clock_o;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("outputs not low in stop");
  property p_manual_quiet;
    !auto_mode_o |=> !clockgen_irq_o;
  endproperty
  a_manual_quiet: assert property (p_manual_quiet)
    else $error("interrupt in manual mode");
  // bits 7:6 of both registers read 0 in manual mode
  property p_manual_reads;
    s_rd_done ##0 !auto_mode_o |-> prdata_o[7:6] == 2'b00;
  endproperty
  a_manual_reads: assert property (p_manual_reads)
    else $error("manual read shows enable, flag or lock");
  property p_ie_off;
    s_ie_off |-> ##2 !clockgen_irq_o;
  endproperty
  a_ie_off: assert property (p_ie_off)
    else $error("interrupt with enable cleared");
  // no read or write in the previous cycle means nothing can clear it
  property p_irq_holds;
    clockgen_irq_o && !$past(psel_i) && oscillator_enable_i |=> clockgen_irq_o;
  endproperty
  a_irq_holds: assert property (p_irq_holds)
    else $error("interrupt level dropped");
  property p_pready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready longer than one cycle");
  property p_access_len;
    psel_i && $rose(penable_i) |=> pready_o;
  endproperty
  a_access_len: assert property (p_access_len)
    else $error("access phase not two cycles");
  // slow sources cannot toggle the base clock on adjacent cycles
  property p_base_slow;
    oscillator_enable_i && $changed(base_clock_out_o) |=> $stable(base_clock_out_o);
  endproperty
  a_base_slow: assert property (p_base_slow)
    else $error("base clock toggles too fast");
  // the pin pipeline is flushed by reset, so only compare once it has refilled
  property p_xtal_copy;
    $past(rst_n_i, 3) && $past(oscillator_enable_i) |->
      crystal_clock_o == $past(crystal_clock_i, 3);
  endproperty
  a_xtal_copy: assert property (p_xtal_copy)
    else $error("crystal output not a copy of the pin");
endmodule : plc_properties

bind plc_top plc_properties #(.ADDR_W(ADDR_W)) u_props (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .crystal_clock_i(crystal_clock_i),
  .oscillator_enable_i(oscillator_enable_i), .crystal_clock_o(crystal_clock_o),
  .base_clock_out_o(base_clock_out_o), .clockgen_irq_o(clockgen_irq_o),
  .auto_mode_o(auto_mode_o));

//--- dv/plc_top_tb_top.sv
// Purpose: self-checking bench for plc_top
// Assumes: slave answers in its own time; only the watchdog ends a wait
// Notes: source clock pins are slow toggles made here
`timescale 1ns/10ps
`include "plc_regs.svh"
module plc_top_tb_top;
  localparam logic [11:0] CTL = `PLC_CTRL_OFF;
  localparam logic [11:0] BWR = `PLC_BW_OFF;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, xtal = 0, vco = 0;
  logic lock = 0, trk = 0, osc = 1, brk = 0, bce = 0, xen = 1, ven = 1, bprev = 0;
  logic pready, pslverr, xo, bo, irq, pwo, mto, amo, err;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prdata, rd;
  int failures = 0, n_tests = 0, cc = 0, nb = 0, n0;

  plc_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .crystal_clock_i(xtal), .vco_clock_i(vco),
    .lock_detect_i(lock), .track_detect_i(trk), .oscillator_enable_i(osc),
    .break_state_i(brk), .break_clear_enable_i(bce), .crystal_clock_o(xo),
    .base_clock_out_o(bo), .clockgen_irq_o(irq), .loop_power_on_o(pwo),
    .manual_track_o(mto), .auto_mode_o(amo));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; an idle edge follows so the next setup is a fresh assignment
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // request held until pready is seen high at a rising edge
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdx(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdx

  task automatic tally_and_finish;
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    forever #25 clk = ~clk;
  end

  // source pins well under a quarter of the ref rate; base toggles are counted
  always @(posedge clk)
  begin
    cc <= cc + 1;
    if (xen && cc % 8 == 0) xtal <= ~xtal;
    if (ven && cc % 5 == 0) vco <= ~vco;
    bprev <= bo;
    if (bo !== bprev) nb <= nb + 1;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdx(CTL, 8'h2F);
    rdx(BWR, 8'h00);
    apb(1'b1, 12'h008, 8'hF0);
    chk(err, 1'b1);
    lock <= 1'b1;
    repeat (8) @(posedge clk);
    rdx(CTL, 8'h2F);
    apb(1'b1, CTL, 8'hA0);
    rdx(CTL, 8'h2F);
    lock <= 1'b0;
    repeat (8) @(posedge clk);
    // manual tracking value is stored and read back while auto is off
    apb(1'b1, BWR, 8'h20);
    chk(mto, 1'b1);
    rdx(BWR, 8'h20);
    apb(1'b1, BWR, 8'h80);
    chk({amo, mto}, 2'b10);
    apb(1'b1, CTL, 8'hA0);
    lock <= 1'b1;
    repeat (8) @(posedge clk);
    chk(irq, 1'b1);
    rdx(BWR, 8'hC0);
    trk <= 1'b1;
    repeat (4) @(posedge clk);
    rdx(BWR, 8'hE0);
    chk(irq, 1'b1);
    rdx(CTL, 8'hEF);
    chk(irq, 1'b0);
    rdx(CTL, 8'hAF);
    // lock exit inside a break, protected and then clearable
    brk <= 1'b1;
    lock <= 1'b0;
    repeat (8) @(posedge clk);
    rdx(CTL, 8'hEF);
    apb(1'b1, CTL, 8'hA0);
    rdx(CTL, 8'hEF);
    bce <= 1'b1;
    rdx(CTL, 8'hEF);
    rdx(CTL, 8'hAF);
    brk <= 1'b0;
    bce <= 1'b0;
    rdx(CTL, 8'hAF);
    apb(1'b1, CTL, 8'h20);
    lock <= 1'b1;
    repeat (8) @(posedge clk);
    chk(irq, 1'b0);
    lock <= 1'b0;
    repeat (8) @(posedge clk);
    rdx(CTL, 8'h6F);
    // select and power interlock, selection while unlocked
    apb(1'b1, CTL, 8'h00);
    chk(pwo, 1'b0);
    apb(1'b1, CTL, 8'h10);
    rdx(CTL, 8'h0F);
    apb(1'b1, CTL, 8'h20);
    apb(1'b1, CTL, 8'h30);
    n0 = nb;
    repeat (30) @(posedge clk);
    chk(nb - n0, 0);
    apb(1'b1, CTL, 8'h10);
    rdx(CTL, 8'h3F);
    repeat (150) @(posedge clk);
    xen <= 1'b0;
    n0 = nb;
    repeat (80) @(posedge clk);
    chk((nb - n0) inside {[7:9]}, 1'b1);
    osc <= 1'b0;
    xen <= 1'b1;
    repeat (4) @(posedge clk);
    chk({irq, bo, xo}, 3'b000);
    osc <= 1'b1;
    ven <= 1'b0;
    apb(1'b0, CTL, 32'h0000_0000);
    chk(rd & 8'h30, 8'h20);
    repeat (20) @(posedge clk);
    n0 = nb;
    repeat (160) @(posedge clk);
    chk((nb - n0) inside {[9:11]}, 1'b1);
    tally_and_finish();
  end
endmodule : plc_top_tb_top

//--- src/plc_pkg.sv
// Purpose: types shared by the loop control block
// Assumes: nothing
// Notes: numbers live in plc_regs.svh
package plc_pkg;

  // software view of loop_control_reg
  typedef struct packed {
    logic irq_en;
    logic flag;
    logic power_on;
    logic src_sel;
  } plc_ctrl_s;

  // software view of loop_bandwidth_reg
  typedef struct packed {
    logic auto_mode;
    logic manual_track;
  } plc_bw_s;

  // base clock switcher
  typedef enum logic [1:0] {
    SW_RUN,
    SW_OLD,
    SW_NEW
  } plc_sw_state_e;

endpackage : plc_pkg

//--- src/plc_regs.svh
// Purpose: register offsets, bit positions, reset values and counts of the loop control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

`define PLC_ADDR_W 12
`define PLC_CTRL_OFF 12'h000
`define PLC_BW_OFF 12'h004

// loop_control_reg bits
`define PLC_CTRL_IE_BIT 7
`define PLC_CTRL_FLAG_BIT 6
`define PLC_CTRL_PWR_BIT 5
`define PLC_CTRL_SEL_BIT 4
`define PLC_CTRL_UNUSED 4'hF

// loop_bandwidth_reg bits
`define PLC_BW_AUTO_BIT 7
`define PLC_BW_LOCK_BIT 6
`define PLC_BW_TRK_BIT 5
`define PLC_BW_XLD_BIT 4

// reset values
`define PLC_RST_IE 1'b0
`define PLC_RST_FLAG 1'b0
`define PLC_RST_PWR 1'b1
`define PLC_RST_SEL 1'b0
`define PLC_RST_AUTO 1'b0
`define PLC_RST_TRK 1'b0

// edges of each source clock the base clock stays static while switching
`define PLC_SWITCH_EDGES 2'h3

`endif

//--- src/plc_sync.sv
// Purpose: two-flop synchroniser for pins entering the ref_clk_i domain
// Assumes: synchronous active-low reset
// Notes: the first stage is read only by the second
`timescale 1ns/10ps
module plc_sync #(
  parameter int unsigned W = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // plain two-stage chain, reset to zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : plc_sync

//--- src/plc_top.sv
// Purpose: loop lock event flag, interrupt and base clock source control
// Assumes: crystal and vco clocks are slow against ref_clk_i and sampled as pins
// Notes: APB slave, two registers; all outputs registered
// Summary of operation
// - auto mode: every lock change outside stop raises request
// - request passed only with irq enable set
// - change flag sets regardless of enable
// - manual mode: no interrupts, flag reads zero
// - vco source selectable even when unlocked
// - source select set: base from vco/2
// - wait mode changes nothing here
// - oscillator enable low: irq, base and crystal clock outputs held low
// - stop clears source select bit
// - after stop: crystal/2, select stays clear
// - break with clear enable: clears still work
// - break without clear enable: flag protected
// - auto mode: tracking flag shows acquisition done
// - auto mode: lock bit shows lock reached
// - control register read clears change flag
// - select/power interlock ignores illegal writes
// - base clock static three edges each side; old side skipped if it is the vco and power is off
`timescale 1ns/10ps
`include "plc_regs.svh"
module plc_top
  import plc_pkg::*;
#(
  parameter int unsigned ADDR_W = `PLC_ADDR_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic crystal_clock_i,
  input wire logic vco_clock_i,
  input wire logic lock_detect_i,
  input wire logic track_detect_i,
  input wire logic oscillator_enable_i,
  input wire logic break_state_i,
  input wire logic break_clear_enable_i,
  output logic crystal_clock_o,
  output logic base_clock_out_o,
  output logic clockgen_irq_o,
  output logic loop_power_on_o,
  output logic manual_track_o,
  output logic auto_mode_o
);

  // word-aligned address match, used by read and write paths
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : addr_is

  // edge of the chosen source clock
  function automatic logic pick_edge(input logic sel, input logic x_e, input logic v_e);
    pick_edge = sel ? v_e : x_e;
  endfunction : pick_edge

  logic [3:0] pin_s;
  logic xclk_s;
  logic vclk_s;
  logic lock_s;
  logic trk_s;

  // every pin from the analog side passes two flops first
  plc_sync #(
    .W(4)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({crystal_clock_i, vco_clock_i, lock_detect_i, track_detect_i}),
    .sync_o(pin_s)
  );

  assign xclk_s = pin_s[3];
  assign vclk_s = pin_s[2];
  assign lock_s = pin_s[1];
  assign trk_s = pin_s[0];

  plc_ctrl_s ctrl_ff;
  plc_ctrl_s nxt_ctrl;
  plc_bw_s bw_ff;
  plc_bw_s nxt_bw;
  logic lock_raw_ff;
  logic trk_raw_ff;
  logic xclk_prev_ff;
  logic vclk_prev_ff;
  logic irq_ff;
  logic nxt_irq;
  logic xout_ff;
  logic nxt_xout;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  plc_sw_state_e sw_ff;
  plc_sw_state_e nxt_sw;
  logic sel_ff;
  logic nxt_sel;
  logic [1:0] edge_cnt_ff;
  logic [1:0] nxt_edge_cnt;
  logic base_ff;
  logic nxt_base;

  logic x_edge;
  logic v_edge;
  logic lock_evt;
  logic access;
  logic take;
  logic done;
  logic hit_ctrl;
  logic hit_bw;
  logic protect;
  logic rd_clr;
  logic trk_bit;

  // bus decode: first access cycle samples, second completes
  always_comb
  begin
    x_edge = xclk_s & ~xclk_prev_ff;
    v_edge = vclk_s & ~vclk_prev_ff;
    access = psel_i & penable_i;
    take = access & ~pready_ff;
    done = access & pready_ff;
    hit_ctrl = addr_is(paddr_i, `PLC_CTRL_OFF);
    hit_bw = addr_is(paddr_i, `PLC_BW_OFF);
    protect = break_state_i & ~break_clear_enable_i;
    // a read, including the read half of read-modify-write, clears the flag
    rd_clr = take & ~pwrite_i & hit_ctrl & ~protect;
    // any lock change while the loop runs in auto mode is an event
    lock_evt = bw_ff.auto_mode & oscillator_enable_i & (lock_s != lock_raw_ff);
    trk_bit = bw_ff.auto_mode ? trk_raw_ff : bw_ff.manual_track;
  end

  // read data and answer timing
  always_comb
  begin
    nxt_pready = take;
    nxt_pslverr = take & ~(hit_ctrl | hit_bw);
    nxt_prdata = 32'h0000_0000;
    if (take && !pwrite_i && hit_ctrl)
    begin
      nxt_prdata[3:0] = `PLC_CTRL_UNUSED;
      nxt_prdata[`PLC_CTRL_IE_BIT] = ctrl_ff.irq_en & bw_ff.auto_mode;
      nxt_prdata[`PLC_CTRL_FLAG_BIT] = ctrl_ff.flag & bw_ff.auto_mode;
      nxt_prdata[`PLC_CTRL_PWR_BIT] = ctrl_ff.power_on;
      nxt_prdata[`PLC_CTRL_SEL_BIT] = ctrl_ff.src_sel;
    end
    else if (take && !pwrite_i && hit_bw)
    begin
      nxt_prdata[`PLC_BW_AUTO_BIT] = bw_ff.auto_mode;
      nxt_prdata[`PLC_BW_LOCK_BIT] = bw_ff.auto_mode & lock_raw_ff;
      nxt_prdata[`PLC_BW_TRK_BIT] = trk_bit;
      nxt_prdata[`PLC_BW_XLD_BIT] = 1'b0; // crystal loss detect not built here
    end
  end

  // register updates; hardware set beats software clear
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_bw = bw_ff;
    if (done && pwrite_i && hit_ctrl)
    begin
      // enable is frozen while manual mode is active
      if (bw_ff.auto_mode)
      begin
        nxt_ctrl.irq_en = pwdata_i[`PLC_CTRL_IE_BIT];
      end
      // power may not drop under a vco-selected base clock
      if (pwdata_i[`PLC_CTRL_PWR_BIT] || !ctrl_ff.src_sel)
      begin
        nxt_ctrl.power_on = pwdata_i[`PLC_CTRL_PWR_BIT];
      end
      // select needs power already on, hence two writes from off; lock is not checked
      if (!pwdata_i[`PLC_CTRL_SEL_BIT] || ctrl_ff.power_on)
      begin
        nxt_ctrl.src_sel = pwdata_i[`PLC_CTRL_SEL_BIT];
      end
    end
    if (done && pwrite_i && hit_bw)
    begin
      // tracking bit is read-only in auto mode; manual value is kept aside
      if (!bw_ff.auto_mode)
      begin
        nxt_bw.manual_track = pwdata_i[`PLC_BW_TRK_BIT];
      end
      nxt_bw.auto_mode = pwdata_i[`PLC_BW_AUTO_BIT];
    end
    if (rd_clr)
    begin
      nxt_ctrl.flag = 1'b0;
    end
    if (lock_evt)
    begin
      nxt_ctrl.flag = 1'b1;
    end
    // stop forces the crystal source; wait mode has no input here at all
    if (!oscillator_enable_i)
    begin
      nxt_ctrl.src_sel = 1'b0;
    end
    // level request, suppressed in manual mode and during stop
    nxt_irq = oscillator_enable_i & bw_ff.auto_mode & ctrl_ff.flag & ctrl_ff.irq_en;
    nxt_xout = oscillator_enable_i & xclk_s;
  end

  // base clock divider and glitch-free source switch
  always_comb
  begin
    nxt_sw = sw_ff;
    nxt_sel = sel_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_base = base_ff;
    if (!oscillator_enable_i)
    begin
      // stopped: output low and crystal already active on recovery
      nxt_sw = SW_RUN;
      nxt_sel = 1'b0;
      nxt_edge_cnt = 2'h0;
      nxt_base = 1'b0;
    end
    else
    begin
      unique case (sw_ff)
        SW_RUN:
        begin
          if (ctrl_ff.src_sel != sel_ff)
          begin
            nxt_sw = SW_OLD;
            nxt_edge_cnt = 2'h0;
          end
          else if (pick_edge(sel_ff, x_edge, v_edge))
          begin
            nxt_base = ~base_ff;
          end
        end
        SW_OLD:
        begin
          // output static; a vco already powered down would never tick
          if (sel_ff && !ctrl_ff.power_on)
          begin
            nxt_sw = SW_NEW;
            nxt_edge_cnt = 2'h0;
          end
          else if (pick_edge(sel_ff, x_edge, v_edge))
          begin
            if (edge_cnt_ff == `PLC_SWITCH_EDGES - 2'h1)
            begin
              nxt_sw = SW_NEW;
              nxt_edge_cnt = 2'h0;
            end
            else
            begin
              nxt_edge_cnt = edge_cnt_ff + 2'h1;
            end
          end
        end
        SW_NEW:
        begin
          if (pick_edge(~sel_ff, x_edge, v_edge))
          begin
            if (edge_cnt_ff == `PLC_SWITCH_EDGES - 2'h1)
            begin
              nxt_sw = SW_RUN;
              nxt_sel = ~sel_ff;
              nxt_edge_cnt = 2'h0;
            end
            else
            begin
              nxt_edge_cnt = edge_cnt_ff + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_ff <= '{irq_en: `PLC_RST_IE, flag: `PLC_RST_FLAG, power_on: `PLC_RST_PWR,
                   src_sel: `PLC_RST_SEL};
      bw_ff <= '{auto_mode: `PLC_RST_AUTO, manual_track: `PLC_RST_TRK};
      lock_raw_ff <= 1'b0;
      trk_raw_ff <= 1'b0;
      xclk_prev_ff <= 1'b0;
      vclk_prev_ff <= 1'b0;
      irq_ff <= 1'b0;
      xout_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      sw_ff <= SW_RUN;
      sel_ff <= 1'b0;
      edge_cnt_ff <= 2'h0;
      base_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      bw_ff <= nxt_bw;
      lock_raw_ff <= lock_s;
      trk_raw_ff <= trk_s;
      xclk_prev_ff <= xclk_s;
      vclk_prev_ff <= vclk_s;
      irq_ff <= nxt_irq;
      xout_ff <= nxt_xout;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      sw_ff <= nxt_sw;
      sel_ff <= nxt_sel;
      edge_cnt_ff <= nxt_edge_cnt;
      base_ff <= nxt_base;
    end
  end

  // outputs straight from flops
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign crystal_clock_o = xout_ff;
  assign base_clock_out_o = base_ff;
  assign clockgen_irq_o = irq_ff;
  assign loop_power_on_o = ctrl_ff.power_on;
  assign manual_track_o = bw_ff.manual_track;
  assign auto_mode_o = bw_ff.auto_mode;

endmodule : plc_top
